/* File: rtl/didec_top.v */
// Digital input function decoder with APB register access
`timescale 1ns/1ps
`default_nettype none
`include "didec_defs.vh"
module didec_top #(
    parameter NT = `DIDEC_NTERM,
    parameter TICK_CYC = (`DIDEC_CLK_HZ / 1000) * `DIDEC_STEP_MS
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire [NT-1:0] digital_input_terminal,
    input wire [15:0] run_freq,
    input wire run_up,
    input wire run_down,
    input wire ramp_stop,
    output reg [2:0] speed_index,
    output reg [15:0] speed_ref,
    output reg ext_fault_alarm,
    output reg stop_request,
    output reg overheat_fault,
    output reg forced_decel,
    output reg [15:0] forced_decel_time,
    output reg direct_stop,
    output reg [3:0] weigh_value,
    output reg [1:0] special_logic,
    output reg [`DIDEC_NFUNC-1:0] func_active,
    output wire [4:0] relay_one_function,
    output wire [4:0] relay_two_function,
    output wire [4:0] relay_three_function,
    output wire [4:0] relay_four_function
);
    localparam NF = `DIDEC_NFUNC;

    reg [NT-1:0] sync1_r;
    reg [NT-1:0] sync2_r;
    reg [7:0] input_filter_time_r;
    reg [7:0] speed_select_filter_time_r;
    reg [7*NT-1:0] func_r;
    reg [31:0] relay_r;
    reg [15:0] forced_decel_threshold_r;
    // Forced decel time rides in the upper half of FDEC
    reg [15:0] fdec_time_r;
    reg [15:0] stored_speed_r [0:7];
    reg ext_fault_r;
    reg [31:0] tick_cnt_r;
    reg tick_r;
    reg [NF-1:0] fn_all;
    wire [NT-1:0] nc;
    wire [NT-1:0] act_raw;
    wire [NT-1:0] act_filt;
    wire [NF*NT-1:0] fn_vec;
    wire [2:0] sel_raw;
    wire [2:0] sel_filt;
    wire setup;
    wire wr;
    wire mapped;
    wire [7:0] wbyte;
    wire [6:0] wcode;
    wire [4:0] rly_one_w;
    wire [4:0] rly_two_w;
    wire [4:0] rly_three_w;
    wire [4:0] rly_four_w;
    integer i;

    // Pins cross into pclk through two flops
    // Only sync2_r feeds logic; sync1_r may still be settling
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_r <= {NT{1'b0}};
            sync2_r <= {NT{1'b0}};
        end else begin
            sync1_r <= digital_input_terminal;
            sync2_r <= sync1_r;
        end
    end

    // Millisecond tick paces both filters; shorten TICK_CYC in simulation
    // Ticks are not aligned to changes, so a setting of n waits n-1 to n ms
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_cnt_r <= 32'h00000000;
            tick_r <= 1'b0;
        end else if (tick_cnt_r >= TICK_CYC - 1) begin
            tick_cnt_r <= 32'h00000000;
            tick_r <= 1'b1;
        end else begin
            tick_cnt_r <= tick_cnt_r + 32'h00000001;
            tick_r <= 1'b0;
        end
    end

    // Limitation: a code write flips polarity before the filter catches up,
    // so the new function can pulse once; clear the fault latch after setup
    genvar g;
    generate
        for (g = 0; g < NT; g = g + 1) begin : g_term
            // Polarity first, so the filter sees the active level
            assign act_raw[g] = sync2_r[g] ^ nc[g]; // R19 R11 R12
            didec_map u_map (
                .code(func_r[7*g +: 7]),
                .act(act_filt[g]),
                .nc(nc[g]),
                .fn(fn_vec[NF*g +: NF])
            );
        end
    endgenerate

    didec_filt #(.W(NT)) u_in_filt (
        .pclk(pclk),
        .presetn(presetn),
        .tick(tick_r),
        .limit(input_filter_time_r),
        .d(act_raw),
        .q(act_filt)
    ); // R17

    // Shared functions ORed, no terminal has priority
    always @* begin
        fn_all = {NF{1'b0}};
        for (i = 0; i < NT; i = i + 1) begin
            fn_all = fn_all | fn_vec[NF*i +: NF]; // R18
        end
    end

    assign sel_raw = {fn_all[`DIDEC_FN_SPD2], fn_all[`DIDEC_FN_SPD1],
                      fn_all[`DIDEC_FN_SPD0]}; // R01

    // Transient combinations during a speed change reach the index only if they outlast the speed select filter time
    didec_filt #(.W(3)) u_spd_filt (
        .pclk(pclk),
        .presetn(presetn),
        .tick(tick_r),
        .limit(speed_select_filter_time_r),
        .d(sel_raw),
        .q(sel_filt)
    ); // R02 R03

    // Decoded commands
    // One cycle behind fn_all; ext_fault_alarm and the external fault part of stop_request lag two through ext_fault_r, speed_index follows sel_filt
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            speed_index <= 3'h0;
            speed_ref <= 16'h0000;
            ext_fault_alarm <= 1'b0;
            stop_request <= 1'b0;
            overheat_fault <= 1'b0;
            forced_decel <= 1'b0;
            forced_decel_time <= 16'h0000;
            direct_stop <= 1'b0;
            weigh_value <= 4'h0;
            special_logic <= 2'h0;
            func_active <= {NF{1'b0}};
        end else begin
            speed_index <= sel_filt; // R01
            speed_ref <= stored_speed_r[sel_filt]; // R01
            ext_fault_alarm <= ext_fault_r; // R04
            overheat_fault <= fn_all[`DIDEC_FN_OVHT]; // R05 R06
            stop_request <= ext_fault_r | fn_all[`DIDEC_FN_OVHT]; // R04
            forced_decel <= ((fn_all[`DIDEC_FN_UPJ] & run_up) |
                             (fn_all[`DIDEC_FN_DNJ] & run_down)) &
                            (run_freq > forced_decel_threshold_r); // R07
            forced_decel_time <= fdec_time_r; // R07
            direct_stop <= ramp_stop & fn_all[`DIDEC_FN_DSTOP]; // R08
            weigh_value <= fn_all[`DIDEC_FN_WGT0 +: 4]; // R09
            special_logic <= {fn_all[`DIDEC_FN_SPL2], fn_all[`DIDEC_FN_SPL1]}; // R10
            func_active <= fn_all;
        end
    end

    // APB: one wait-free access; read data captured in setup
    assign setup = psel & ~penable;
    assign wr = psel & penable & pwrite;
    assign mapped = (paddr[1:0] == 2'b00) &&
                    ((paddr <= `DIDEC_A_FAULT) ||
                     (paddr >= `DIDEC_A_SPD0 && paddr <= `DIDEC_A_LAST));
    assign pready = 1'b1;
    // Error only in the access phase; unmapped writes are dropped
    assign pslverr = psel & penable & ~mapped;
    assign wbyte = pwdata[7:0];
    assign wcode = pwdata[6:0];
    assign rly_one_w = pwdata[4:0];
    assign rly_two_w = pwdata[12:8];
    assign rly_three_w = pwdata[20:16];
    assign rly_four_w = pwdata[28:24];
    assign relay_one_function = relay_r[4:0];
    assign relay_two_function = relay_r[12:8];
    assign relay_three_function = relay_r[20:16];
    assign relay_four_function = relay_r[28:24];

    // Register writes land in the access cycle only
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            input_filter_time_r <= `DIDEC_FT_RST;
            speed_select_filter_time_r <= `DIDEC_FT_RST;
            func_r <= `DIDEC_FUNC_RST;
            relay_r <= `DIDEC_RLY_RST;
            forced_decel_threshold_r <= 16'h0000;
            fdec_time_r <= 16'h0000;
            for (i = 0; i < 8; i = i + 1) begin
                stored_speed_r[i] <= 16'h0000;
            end
        end else if (wr && mapped) begin
            case (paddr)
                `DIDEC_A_FILT: begin
                    if (wbyte >= `DIDEC_IFT_MIN && wbyte <= `DIDEC_FT_MAX) begin
                        input_filter_time_r <= wbyte; // R17
                    end
                    if (pwdata[15:8] <= `DIDEC_FT_MAX) begin
                        speed_select_filter_time_r <= pwdata[15:8]; // R02
                    end
                end
                `DIDEC_A_RELAY: begin
                    // Out-of-range selectors keep their old value
                    if (rly_one_w >= `DIDEC_RLY_FLT_MIN && rly_one_w <= `DIDEC_RLY_MAX) begin
                        relay_r[4:0] <= rly_one_w; // R15
                    end
                    if (rly_two_w <= `DIDEC_RLY_MAX) begin
                        relay_r[12:8] <= rly_two_w; // R15
                    end
                    if (rly_three_w <= `DIDEC_RLY_MAX) begin
                        relay_r[20:16] <= rly_three_w; // R15
                    end
                    if (rly_four_w <= `DIDEC_RLY_MAX) begin
                        relay_r[28:24] <= rly_four_w; // R15
                    end
                end
                `DIDEC_A_FDEC: begin
                    forced_decel_threshold_r <= pwdata[15:0]; // R07
                    fdec_time_r <= pwdata[31:16];
                end
                default: begin
                    // STAT and unused words fall through here and change nothing
                    for (i = 0; i < NT; i = i + 1) begin
                        if (paddr == `DIDEC_A_FUNC0 + 8'd4 * i[7:0] &&
                            wcode <= `DIDEC_CODE_MAX && !pwdata[7]) begin
                            func_r[7*i +: 7] <= wcode; // R11
                        end
                    end
                    for (i = 0; i < 8; i = i + 1) begin
                        if (paddr == `DIDEC_A_SPD0 + 8'd4 * i[7:0]) begin
                            stored_speed_r[i] <= pwdata[15:0]; // R01
                        end
                    end
                end
            endcase
        end
    end

    // External fault latches; a new fault wins over a clear
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_fault_r <= 1'b0;
        end else if (fn_all[`DIDEC_FN_EXTF]) begin
            ext_fault_r <= 1'b1; // R04
        end else if (wr && paddr == `DIDEC_A_FAULT && pwdata[0]) begin
            ext_fault_r <= 1'b0;
        end
    end

    // Read data taken in setup, so the access phase needs no wait state
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (setup) begin
            prdata <= 32'h00000000;
            case (paddr)
                `DIDEC_A_FILT: prdata <= {16'h0000, speed_select_filter_time_r,
                                          input_filter_time_r};
                `DIDEC_A_RELAY: prdata <= {3'h0, relay_r[28:24], 3'h0, relay_r[20:16],
                                           3'h0, relay_r[12:8], 3'h0, relay_r[4:0]};
                `DIDEC_A_FDEC: prdata <= {fdec_time_r, forced_decel_threshold_r};
                `DIDEC_A_STAT: prdata <= {5'h00, sel_filt, 3'h0, direct_stop,
                                          forced_decel, fn_all[`DIDEC_FN_OVHT],
                                          ext_fault_r, weigh_value[0], 6'h00,
                                          act_filt[9:0]};
                `DIDEC_A_FAULT: prdata <= {31'h00000000, ext_fault_r};
                default: begin
                    for (i = 0; i < NT; i = i + 1) begin
                        if (paddr == `DIDEC_A_FUNC0 + 8'd4 * i[7:0]) begin
                            prdata <= {25'h0000000, func_r[7*i +: 7]};
                        end
                    end
                    for (i = 0; i < 8; i = i + 1) begin
                        if (paddr == `DIDEC_A_SPD0 + 8'd4 * i[7:0]) begin
                            prdata <= {16'h0000, stored_speed_r[i]};
                        end
                    end
                end
            endcase
        end
    end
endmodule // didec_top
`default_nettype wire

/* File: rtl/didec_defs.vh */
// Constants of the digital input function decoder
// Operation
// R01: Three select inputs form index, bit2 most significant, choosing stored speed zero..seven.
// R02: Speed select filter time defaults 20 ms, 1 ms step, range 0 to 200 ms.
// R03: Speed index holds until select inputs stay stable for the filter time.
// R04: Active external fault input raises an alarm and stops running.
// R05: Motor overheat input, open or closed type, triggers overheat protection while active.
// R06: Overheat fault clears by itself when the input goes inactive.
// R07: Forced decel switch for current direction over threshold frequency requests timed stop.
// R08: Direct stop input during ramp-to-stop stops the drive at once.
// R09: Four function values give four weighing bits forming a digital load value.
// R10: Special preset speed logic functions are only for the special speed mode.
// R11: Function code range 0-122; hundreds digit 1 means normally closed input.
// R12: Hundreds digit 0 means normally open input.
// R13: Lower two decimal digits select the terminal's input function.
// R14: Selector above 22 drives no function.
// R15: Relay selectors range 0-18; fault relay selector range 1-18.
// R16: Selected function 0 causes no action at any level.
// R17: Shared input filter time defaults 20 ms, range 1 to 200 ms.
// R18: Terminals sharing one function are ORed together.
// R19: Polarity applied to raw level before filtering and decoding.
`ifndef DIDEC_DEFS_VH
`define DIDEC_DEFS_VH

`define DIDEC_CLK_HZ 10000000
`define DIDEC_STEP_MS 1
`define DIDEC_NTERM 10
`define DIDEC_NFUNC 23
`define DIDEC_FN_MAX 7'd22
`define DIDEC_CODE_MAX 7'd122
`define DIDEC_NC_BASE 7'd100
`define DIDEC_FT_MAX 8'd200
`define DIDEC_IFT_MIN 8'd1
`define DIDEC_FT_RST 8'd20
`define DIDEC_RLY_MAX 5'd18
`define DIDEC_RLY_FLT_MIN 5'd1

// Function selectors
`define DIDEC_FN_SPD0 3
`define DIDEC_FN_SPD1 4
`define DIDEC_FN_SPD2 5
`define DIDEC_FN_WGT0 12
`define DIDEC_FN_EXTF 16
`define DIDEC_FN_OVHT 17
`define DIDEC_FN_UPJ 18
`define DIDEC_FN_DNJ 19
`define DIDEC_FN_SPL1 20
`define DIDEC_FN_SPL2 21
`define DIDEC_FN_DSTOP 22

// Register byte offsets
`define DIDEC_A_FILT 8'h00
`define DIDEC_A_FUNC0 8'h04
`define DIDEC_A_RELAY 8'h2C
`define DIDEC_A_FDEC 8'h30
`define DIDEC_A_STAT 8'h34
`define DIDEC_A_FAULT 8'h38
`define DIDEC_A_SPD0 8'h40
`define DIDEC_A_LAST 8'h5C

// Reset values
`define DIDEC_FUNC_RST 70'h0000001C305080C101
`define DIDEC_RLY_RST 32'h06050104
`define DIDEC_FDEC_RST 32'h00000000

`endif

/* File: rtl/didec_filt.v */
// Stability filter: output follows input after it holds steady for a number of ticks
`timescale 1ns/1ps
`default_nettype none
module didec_filt #(
    parameter W = 3
) (
    input wire pclk,
    input wire presetn,
    input wire tick,
    input wire [7:0] limit,
    input wire [W-1:0] d,
    output reg [W-1:0] q
);
    reg [W-1:0] cand_r;
    reg [7:0] cnt_r;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cand_r <= {W{1'b0}};
            cnt_r <= 8'h00;
            q <= {W{1'b0}};
        end else if (d != cand_r) begin
            // Any change restarts the stability window
            cand_r <= d;
            cnt_r <= 8'h00;
        end else if (cnt_r >= limit) begin
            q <= cand_r;
        end else if (tick) begin
            cnt_r <= cnt_r + 8'h01;
        end
    end
endmodule // didec_filt
`default_nettype wire

/* File: rtl/didec_map.v */
// Function code decoder for one terminal
`timescale 1ns/1ps
`default_nettype none
`include "didec_defs.vh"
module didec_map (
    input wire [6:0] code,
    input wire act,
    output wire nc,
    output reg [`DIDEC_NFUNC-1:0] fn
);
    wire [6:0] sel;
    assign nc = (code >= `DIDEC_NC_BASE); // R11 R12
    assign sel = nc ? code - `DIDEC_NC_BASE : code; // R13

    always @* begin
        fn = {`DIDEC_NFUNC{1'b0}};
        // Selector 0 and anything above the last function stay silent
        if (sel != 7'd0 && sel <= `DIDEC_FN_MAX) begin // R14 R16
            fn[sel[4:0]] = act;
        end
    end
endmodule // didec_map
`default_nettype wire

/* File: rtl/didec_fix.v */
// Spare unit with no module in it
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

/* File: testbench/didec_sva.sv */
// Port assertions for the digital input function decoder
`timescale 1ns/1ps
`default_nettype none
`include "didec_defs.vh"
module didec_sva (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [7:0] paddr,
    input wire logic pslverr,
    input wire logic [15:0] run_freq,
    input wire logic run_up,
    input wire logic run_down,
    input wire logic ramp_stop,
    input wire logic ext_fault_alarm,
    input wire logic stop_request,
    input wire logic overheat_fault,
    input wire logic forced_decel,
    input wire logic direct_stop,
    input wire logic [3:0] weigh_value,
    input wire logic [`DIDEC_NFUNC-1:0] func_active,
    input wire logic [4:0] relay_one_function,
    input wire logic [4:0] relay_two_function
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    bad_addr_a: assert property (psel && penable && paddr > 8'h5C |-> pslverr)
        else $error("unmapped access gave no error");
    ext_latch_a: assert property (func_active[16] [*3] |=> ext_fault_alarm)
        else $error("active external fault not latched");
    stop_req_a: assert property ($rose(ext_fault_alarm) || $rose(overheat_fault) |-> ##[0:1] stop_request)
        else $error("fault without stop request");
    ovht_follow_a: assert property ($stable(func_active[17]) [*3] |-> overheat_fault == func_active[17])
        else $error("overheat flag not following input");
    weigh_bits_a: assert property ($stable(func_active[15:12]) [*3] |-> weigh_value == func_active[15:12])
        else $error("weighing value mismatch");
    no_func_a: assert property (!func_active[0])
        else $error("function zero active");
    dstop_ramp_a: assert property (!ramp_stop [*3] |=> !direct_stop)
        else $error("direct stop outside ramp stop");
    fdec_dir_a: assert property ((!run_up && !run_down) [*3] |=> !forced_decel)
        else $error("forced decel without direction");
    fdec_thr_a: assert property ((run_freq == 16'h0000) [*3] |=> !forced_decel)
        else $error("forced decel at zero frequency");
    relay_rng_a: assert property (relay_one_function inside {[5'd1:5'd18]} && relay_two_function <= 5'd18)
        else $error("relay selector out of range");
endmodule // didec_sva
bind didec_top didec_sva i_didec_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .paddr(paddr), .pslverr(pslverr), .run_freq(run_freq),
    .run_up(run_up), .run_down(run_down), .ramp_stop(ramp_stop),
    .ext_fault_alarm(ext_fault_alarm), .stop_request(stop_request),
    .overheat_fault(overheat_fault), .forced_decel(forced_decel), .direct_stop(direct_stop),
    .weigh_value(weigh_value), .func_active(func_active),
    .relay_one_function(relay_one_function), .relay_two_function(relay_two_function));
`default_nettype wire

/* File: testbench/didec_ctl_model.sv */
// Model of the elevator controller that drives the input terminals
`timescale 1ns/1ps
`default_nettype none
module didec_ctl_model (
    input wire logic pclk,
    output logic [9:0] pins
);
    // Closed contact on the normally closed fault terminal at rest
    initial pins = 10'h080;
    // Relay dispersion: select bits move one at a time, 5 cycles apart
    task automatic speed(input logic [2:0] k);
        for (int b = 0; b < 3; b++) begin
            repeat (5) @(posedge pclk);
            pins[2 + b] <= k[b];
        end
    endtask
    task automatic pin(input int n, input logic v);
        @(posedge pclk);
        pins[n] <= v;
    endtask
endmodule // didec_ctl_model
`default_nettype wire

/* File: testbench/tb_digital_input_function_decoder.sv */
// Self-checking testbench for the digital input function decoder
`timescale 1ns/1ps
`default_nettype none
`include "didec_defs.vh"
module tb_digital_input_function_decoder;
    localparam int TK = 10;
    // Input filter 1 ms plus speed filter 2 ms, each doubled, plus pipeline
    localparam int SETTLE = 6 * TK + 12;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic run_up = 1'b0, run_down = 1'b0, ramp_stop = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic [15:0] run_freq = 16'h0000;
    wire [31:0] prdata;
    wire pready, pslverr, ext_fault_alarm, stop_request, overheat_fault, forced_decel, direct_stop;
    wire [2:0] speed_index;
    wire [15:0] speed_ref, fd_time;
    wire [3:0] weigh_value;
    wire [`DIDEC_NFUNC-1:0] func_active;
    wire [4:0] rly1, rly2, rly3, rly4;
    wire [1:0] spl;
    wire [9:0] pins;
    int mismatches = 0;
    int n_tests = 0;
    logic [31:0] exp_q[$], msk_q[$], spd[8], e, m;
    logic [2:0] k, prev = 3'h0;
    logic err, bad;
    initial forever #50 pclk = ~pclk;
    didec_top #(.TICK_CYC(TK)) i_didec_top (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .digital_input_terminal(pins), .run_freq(run_freq),
        .run_up(run_up), .run_down(run_down), .ramp_stop(ramp_stop), .speed_index(speed_index),
        .speed_ref(speed_ref), .ext_fault_alarm(ext_fault_alarm), .stop_request(stop_request),
        .overheat_fault(overheat_fault), .forced_decel(forced_decel),
        .forced_decel_time(fd_time), .direct_stop(direct_stop), .weigh_value(weigh_value),
        .special_logic(spl), .func_active(func_active), .relay_one_function(rly1),
        .relay_two_function(rly2), .relay_three_function(rly3), .relay_four_function(rly4));
    didec_ctl_model i_didec_ctl_model (.pclk(pclk), .pins(pins));
    task automatic chk(input logic [31:0] got, input logic [31:0] ex);
        n_tests++;
        if (got !== ex) begin
            mismatches++;
            $display("[FAIL] %0t got %h expected %h", $time, got, ex);
        end
    endtask
    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic apb(input logic wr_en, input logic [7:0] a, input logic [31:0] d);
        int t;
        psel <= 1'b1;
        pwrite <= wr_en;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (t = 0; t < 50; t++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (t == 50) begin
            mismatches++;
            print_verdict();
        end
        // Idle edge so the next setup never lands in the release time step
        @(posedge pclk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] mk, input logic [31:0] ex);
        msk_q.push_back(mk);
        exp_q.push_back(ex);
        apb(1'b0, a, 32'h00000000);
    endtask
    task automatic settle();
        repeat (SETTLE) @(posedge pclk);
    endtask
    always @(posedge pclk) begin
        if (psel && penable && pready && !pwrite && !pslverr && exp_q.size() > 0) begin
            m = msk_q.pop_front();
            e = exp_q.pop_front();
            chk(prdata & m, e);
        end
    end
    initial begin
        void'($urandom(32'h738AA3F6));
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk({rly1, rly2, rly3, rly4}, {5'd4, 5'd1, 5'd5, 5'd6});
        rd(8'h04, 32'h0000007F, 32'h00000001);
        apb(1'b1, `DIDEC_A_FILT, 32'h00000201);
        apb(1'b1, `DIDEC_A_FILT, 32'h00000200);
        rd(`DIDEC_A_FILT, 32'h0000FFFF, 32'h00000201);
        // No special speed logic codes in an ordinary setup
        apb(1'b1, 8'h04, 32'd23);
        apb(1'b1, 8'h08, 32'd18);
        apb(1'b1, 8'h18, 32'd12);
        apb(1'b1, 8'h1C, 32'd12);
        apb(1'b1, 8'h20, 32'd116);
        apb(1'b1, 8'h24, 32'd17);
        apb(1'b1, 8'h28, 32'd22);
        apb(1'b1, `DIDEC_A_FDEC, {16'h0123, 16'd1000});
        for (int j = 0; j < 8; j++) begin
            spd[j] = $urandom & 32'h0000FFFF;
            apb(1'b1, 8'h40 + 8'(4 * j), spd[j]);
        end
        apb(1'b0, 8'h60, 32'h00000000);
        chk(err, 1'b1);
        for (int i = 0; i < 11; i++) begin
            k = (i < 8) ? (i[2:0] ^ 3'h5) : 3'($urandom);
            i_didec_ctl_model.speed(k);
            chk(speed_index, prev);
            bad = 1'b0;
            repeat (SETTLE) begin
                @(posedge pclk);
                if (speed_index !== prev && speed_index !== k) bad = 1'b1;
            end
            chk(bad, 1'b0);
            chk({speed_index, speed_ref}, {k, spd[k][15:0]});
            rd(`DIDEC_A_STAT, 32'h07000000, {5'h00, k, 24'h000000});
            prev = k;
        end
        // Polarity switch during setup may have latched the fault; start clean
        apb(1'b1, `DIDEC_A_FAULT, 32'h00000001);
        @(posedge pclk);
        chk({ext_fault_alarm, stop_request}, 2'b00);
        i_didec_ctl_model.pin(7, 1'b0);
        settle();
        chk({ext_fault_alarm, stop_request}, 2'b11);
        apb(1'b1, `DIDEC_A_FAULT, 32'h00000001);
        rd(`DIDEC_A_STAT, 32'h00020000, 32'h00020000);
        i_didec_ctl_model.pin(7, 1'b1);
        settle();
        chk(ext_fault_alarm, 1'b1);
        apb(1'b1, `DIDEC_A_FAULT, 32'h00000001);
        rd(`DIDEC_A_STAT, 32'h00020000, 32'h00000000);
        i_didec_ctl_model.pin(8, 1'b1);
        settle();
        chk({overheat_fault, stop_request}, 2'b11);
        i_didec_ctl_model.pin(8, 1'b0);
        settle();
        chk({overheat_fault, stop_request}, 2'b00);
        i_didec_ctl_model.pin(6, 1'b1);
        i_didec_ctl_model.pin(0, 1'b1);
        settle();
        chk(func_active, (32'(prev) << 3) | 32'h00001000);
        chk(weigh_value, 4'h1);
        chk(spl, 2'b00);
        run_up <= 1'b1;
        run_freq <= 16'd1001 + 16'($urandom % 5000);
        i_didec_ctl_model.pin(1, 1'b1);
        settle();
        chk({forced_decel, fd_time}, {1'b1, 16'h0123});
        run_freq <= 16'd1000;
        settle();
        chk(forced_decel, 1'b0);
        run_freq <= 16'd2000;
        run_up <= 1'b0;
        run_down <= 1'b1;
        settle();
        chk(forced_decel, 1'b0);
        i_didec_ctl_model.pin(9, 1'b1);
        settle();
        chk(direct_stop, 1'b0);
        ramp_stop <= 1'b1;
        settle();
        chk(direct_stop, 1'b1);
        print_verdict();
    end
endmodule // tb_digital_input_function_decoder
`default_nettype wire
